// *** src/print_fmt_pkg.sv ***
/*
  Shared types and constants of the print message formatter.
  Assumes a single 40 MHz clock domain and synchronous reset.
*/
`default_nettype none
package print_fmt_pkg;
  // ===========================================================
  // Limits and codes
  localparam int unsigned MAX_CHARS   = 128;
  localparam logic [15:0] ERR_INVALID = 16'h01F3;
  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [7:0]  CH_SPACE    = 8'h20;
  localparam logic [7:0]  CH_QUOTE    = 8'h22;
  localparam logic [7:0]  CH_DOLLAR   = 8'h24;
  localparam logic [7:0]  CH_LF       = 8'h0A;
  localparam logic [7:0]  CH_CR       = 8'h0D;
  localparam logic [7:0]  CH_FF       = 8'h0C;
  localparam logic [7:0]  CH_TAB      = 8'h09;
  localparam int unsigned BUF_DEPTH   = 2;

  // ===========================================================
  // Source word kinds
  typedef enum logic [1:0] {
    SRC_TEXT   = 2'b00,
    SRC_ASCII  = 2'b01,
    SRC_HEX    = 2'b10,
    SRC_END    = 2'b11
  } src_kind_t;

  // One source item handed in by the command sequencer.
  typedef struct packed {
    src_kind_t   kind;
    logic [15:0] data;
  } src_item_t;

  // One printable byte heading for the transmitter.
  typedef struct packed {
    logic [7:0] ch;
    logic       last;
  } out_byte_t;
endpackage
`default_nettype wire

// *** src/print_message_formatter.sv ***
/*
  Print message formatter: turns text-element characters, ASCII-pair
  constant words and hex-digit-pair constant words into a byte stream
  for a serial transmitter to a printer.
  Assumes the port is configured outside, items arrive valid/ready, and
  the transmitter accepts bytes valid/ready on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module print_message_formatter
  import print_fmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        printStart,
  input  wire logic        portConfigured,
  input  wire logic        srcValid,
  output logic             srcReady,
  input  wire src_item_t   srcItem,
  output logic             txValid,
  input  wire logic        txReady,
  output logic [7:0]       txData,
  output logic             portBusyFlag,
  output logic             portCommErrorFlag,
  output logic [15:0]      errorCode
);
  // ===========================================================
  // Parser state
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_OPEN  = 6'b000010,
    S_BODY  = 6'b000100,
    S_ESC   = 6'b001000,
    S_HEX2  = 6'b010000,
    S_EMIT  = 6'b100000
  } state_t;

  state_t      state_reg, state_next;
  logic [7:0]  pend_reg, pend_next;     // Byte waiting for buffer room.
  logic [7:0]  pend2_reg, pend2_next;   // Second byte of a pair.
  logic        have2_reg, have2_next;
  logic [3:0]  hexHi_reg, hexHi_next;
  logic [7:0]  count_reg, count_next;
  logic        err_reg, err_next;
  logic        inText_reg, inText_next;

  // Buffer write side.
  logic        bufWrValid;
  logic        bufWrReady;
  out_byte_t   bufWrData;

  // Hex digit decode; returns 5'h10 when the code is not a hex digit.
  function automatic logic [4:0] hexVal(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hexVal = {1'b0, c[3:0]};
    else if ((c | 8'h20) >= 8'h61 && (c | 8'h20) <= 8'h66)
      hexVal = {1'b0, 4'((c | 8'h20) - 8'h57)};
    else hexVal = 5'h10;
  endfunction

  logic [7:0] srcChar;
  logic [7:0] lower;
  logic [4:0] hv;
  assign srcChar = srcItem.data[7:0];
  assign lower   = srcChar | 8'h20;
  assign hv      = hexVal(srcChar);

  // ===========================================================
  // Next-state logic for the parser and the byte emitter.
  always_comb begin
    state_next  = state_reg;
    pend_next   = pend_reg;
    pend2_next  = pend2_reg;
    have2_next  = have2_reg;
    hexHi_next  = hexHi_reg;
    count_next  = count_reg;
    err_next    = err_reg;
    inText_next = inText_reg;
    srcReady    = 1'b0;
    bufWrValid  = 1'b0;
    bufWrData   = '{ch: pend_reg, last: 1'b0};
    unique case (state_reg)
      S_IDLE: begin
        if (printStart && portConfigured) begin
          state_next = S_OPEN;
          count_next = 8'h00;
          err_next   = 1'b0;
          inText_next = 1'b0;
        end
      end
      S_OPEN, S_BODY, S_ESC, S_HEX2: begin
        srcReady = 1'b1;
        if (srcValid) begin
          if (srcItem.kind == SRC_END) begin
            // An unterminated text or escape is invalid text.
            if (state_reg != S_OPEN || inText_reg)
              err_next = 1'b1;
            state_next = S_IDLE;
          end else if (srcItem.kind != SRC_TEXT) begin
            // Constant words are outside any text element.
            if (state_reg != S_OPEN) begin
              err_next = 1'b1;
              state_next = S_IDLE;
            end else begin
              have2_next = 1'b1;
              state_next = S_EMIT;
              if (srcItem.kind == SRC_ASCII &&
                  srcItem.data[15:8] == 8'h00) begin
                pend_next  = CH_SPACE;
                pend2_next = srcItem.data[7:0];
              end else begin
                pend_next  = srcItem.data[15:8];
                pend2_next = srcItem.data[7:0];
              end
            end
          end else begin
            unique case (state_reg)
              S_OPEN: begin
                if (srcChar == CH_QUOTE) begin
                  state_next  = S_BODY;
                  inText_next = 1'b1;
                end else if (srcChar != CH_SPACE) begin
                  err_next   = 1'b1;
                  state_next = S_IDLE;
                end
              end
              S_BODY: begin
                if (srcChar == CH_QUOTE) begin
                  state_next  = S_OPEN;
                  inText_next = 1'b0;
                end else if (srcChar == CH_DOLLAR) begin
                  state_next = S_ESC;
                end else begin
                  pend_next  = srcChar;
                  have2_next = 1'b0;
                  state_next = S_EMIT;
                end
              end
              S_ESC: begin
                have2_next = 1'b0;
                state_next = S_EMIT;
                if (srcChar == CH_DOLLAR || srcChar == CH_QUOTE)
                  pend_next = srcChar;
                else if (lower == 8'h6E) begin
                  pend_next  = CH_CR;
                  pend2_next = CH_LF;
                  have2_next = 1'b1;
                end else if (lower == 8'h6C) pend_next = CH_LF;
                else if (lower == 8'h70) pend_next = CH_FF;
                else if (lower == 8'h72) pend_next = CH_CR;
                else if (lower == 8'h74) pend_next = CH_TAB;
                else if (!hv[4]) begin
                  hexHi_next = hv[3:0];
                  state_next = S_HEX2;
                end else begin
                  err_next   = 1'b1;
                  state_next = S_IDLE;
                end
              end
              S_HEX2: begin
                if (!hv[4]) begin
                  pend_next  = {hexHi_reg, hv[3:0]};
                  have2_next = 1'b0;
                  state_next = S_EMIT;
                end else begin
                  err_next   = 1'b1;
                  state_next = S_IDLE;
                end
              end
            endcase
          end
        end
      end
      S_EMIT: begin
        // Characters past the limit are dropped, not sent.
        if (count_reg >= 8'(MAX_CHARS)) begin
          have2_next = 1'b0;
          state_next = inText_reg ? S_BODY : S_OPEN;
        end else begin
          bufWrValid = 1'b1;
          if (bufWrReady) begin
            count_next = count_reg + 8'h01;
            if (have2_reg) begin
              pend_next  = pend2_reg;
              have2_next = 1'b0;
            end else begin
              state_next = inText_reg ? S_BODY : S_OPEN;
            end
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg  <= S_IDLE;
      pend_reg   <= 8'h00;
      pend2_reg  <= 8'h00;
      have2_reg  <= 1'b0;
      hexHi_reg  <= 4'h0;
      count_reg  <= 8'h00;
      err_reg    <= 1'b0;
      inText_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      pend_reg   <= pend_next;
      pend2_reg  <= pend2_next;
      have2_reg  <= have2_next;
      hexHi_reg  <= hexHi_next;
      count_reg  <= count_next;
      err_reg    <= err_next;
      inText_reg <= inText_next;
    end
  end

  // ===========================================================
  // Two-entry buffer so a transmitter stall loses no byte.
  logic [7:0] mem_reg [BUF_DEPTH];
  logic [7:0] mem_next [BUF_DEPTH];
  logic       wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] fill_reg, fill_next;
  logic       doWr, doRd;

  assign bufWrReady = (fill_reg != 2'h2);
  assign txValid    = (fill_reg != 2'h0);
  assign txData     = mem_reg[rp_reg];
  assign doWr       = bufWrValid && bufWrReady;
  assign doRd       = txValid && txReady;

  always_comb begin
    mem_next = mem_reg;
    wp_next = wp_reg ^ doWr;
    rp_next = rp_reg ^ doRd;
    fill_next = fill_reg + 2'(doWr) - 2'(doRd);
    if (doWr) mem_next[wp_reg] = bufWrData.ch;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_reg  <= '{default: 8'h00};
      wp_reg   <= 1'b0;
      rp_reg   <= 1'b0;
      fill_reg <= 2'h0;
    end else begin
      mem_reg  <= mem_next;
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      fill_reg <= fill_next;
    end
  end

  // ===========================================================
  // Status flags seen by the program.
  assign portBusyFlag      = (state_reg != S_IDLE) || txValid;
  assign portCommErrorFlag = err_reg;
  assign errorCode         = err_reg ? ERR_INVALID : ERR_NONE;

  // ===========================================================
  // Checks.
  a_buffer_no_overflow: assert property (@(posedge clk) disable iff (srst)
    fill_reg <= 2'h2) else $error("Buffer over fill.");
  a_tx_holds_stall: assert property (@(posedge clk) disable iff (srst)
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("Byte lost under stall.");
  a_count_limit: assert property (@(posedge clk) disable iff (srst)
    count_reg <= 8'(MAX_CHARS)) else $error("Too many chars.");
  a_start_needs_config: assert property (@(posedge clk) disable iff (srst)
    state_reg == S_IDLE && !portConfigured |=> state_reg == S_IDLE)
    else $error("Print without config.");
  a_error_code: assert property (@(posedge clk) disable iff (srst)
    portCommErrorFlag |-> errorCode == ERR_INVALID)
    else $error("Wrong error code.");
  a_crlf_pair: assert property (@(posedge clk) disable iff (srst)
    state_reg == S_ESC && srcValid && srcItem.kind == SRC_TEXT &&
    lower == 8'h6E |=> pend_reg == CH_CR && have2_reg)
    else $error("CR LF not queued.");
  a_single_pad: assert property (@(posedge clk) disable iff (srst)
    state_reg == S_OPEN && srcValid && srcItem.kind == SRC_ASCII &&
    srcItem.data[15:8] == 8'h00 |=> pend_reg == CH_SPACE)
    else $error("No leading space.");
  a_bad_escape: assert property (@(posedge clk) disable iff (srst)
    state_reg == S_HEX2 && srcValid && srcItem.kind == SRC_TEXT &&
    hv[4] |=> err_reg && state_reg == S_IDLE)
    else $error("Bad hex not flagged.");
endmodule // print_message_formatter
`default_nettype wire

// *** testbench/printer_model.sv ***
/*
  Serial printer model that takes formatted bytes off the transmit side.
  Assumes one clock, sync reset, and the bench choosing fast or slow pace.
*/
`timescale 1ns/1ps
`default_nettype none
module printer_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output var  logic       txReady
);
  // ==========================================================
  // Pacing
  logic [1:0] phase = 2'h0;
  logic [7:0] got[$];
  // A slow printer takes one byte in four cycles so the buffer backs up.
  always @(negedge clk) begin
    phase <= srst ? 2'h0 : phase + 2'h1;
    txReady <= !srst && (!slow || phase == 2'h3);
  end
  // Raw bytes land in arrival order; the link adds no framing.
  always @(posedge clk) begin
    if (!srst && txValid && txReady) begin
      got.push_back(txData);
    end
  end
endmodule // printer_model
`default_nettype wire

// *** testbench/testbench.sv ***
/*
  Self-checking bench of the print message formatter.
  Assumes the package and design sources and the printer model.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import print_fmt_pkg::*;
  // ==========================================================
  // Signals
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       printStart = 1'b0;
  logic       portConfigured = 1'b1;
  logic       srcValid = 1'b0;
  logic       slow = 1'b0;
  src_item_t  srcItem = '0;
  logic       srcReady, txValid, txReady, portBusyFlag, portCommErrorFlag;
  logic [7:0] txData;
  logic [15:0] errorCode;
  int         n_errors = 0;
  int         checks = 0;
  src_item_t  items[$];
  logic [7:0] expq[$];
  always #12.5 clk = ~clk;
  print_message_formatter u_print_message_formatter (.clk(clk),
    .srst(srst), .printStart(printStart), .portConfigured(portConfigured),
    .srcValid(srcValid), .srcReady(srcReady), .srcItem(srcItem),
    .txValid(txValid), .txReady(txReady), .txData(txData),
    .portBusyFlag(portBusyFlag), .portCommErrorFlag(portCommErrorFlag),
    .errorCode(errorCode));
  printer_model u_printer_model (.clk(clk), .srst(srst), .slow(slow),
    .txValid(txValid), .txData(txData), .txReady(txReady));
  // ==========================================================
  // Helpers
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] seen, input logic [15:0] e);
    checks++;
    if (seen !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, seen);
    end
  endtask
  task timeout(input string what);
    n_errors++;
    $display("BAD %s expected done seen timeout", what);
    end_sim;
  endtask
  task add(input src_kind_t k, input logic [15:0] d);
    items.push_back('{kind: k, data: d});
  endtask
  task text(input string s);
    foreach (s[i]) add(SRC_TEXT, {8'h00, s[i]});
  endtask
  // Holds the item until the edge where ready is seen; valid stays up.
  task send(input src_item_t it);
    int n;
    n = 0;
    srcItem = it;
    srcValid = 1'b1;
    #1;
    while (srcReady !== 1'b1) begin
      n++;
      if (n > 500) timeout("srcReady");
      @(negedge clk);
      #1;
    end
    @(posedge clk);
    @(negedge clk);
  endtask
  // One edge pulse starts the print, like a rising-edge contact.
  task pulse;
    @(negedge clk);
    chk("busy before start", portBusyFlag, 1'b0);
    printStart = 1'b1;
    @(negedge clk);
    printStart = 1'b0;
  endtask
  task run_msg(input string name, input bit cmp);
    int n;
    pulse();
    chk("busy", portBusyFlag, 1'b1);
    foreach (items[i]) send(items[i]);
    srcValid = 1'b0;
    n = 0;
    while (portBusyFlag !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 3000) timeout("idle");
    end
    if (cmp) begin
      chk("count", 16'(u_printer_model.got.size()), 16'(expq.size()));
      foreach (expq[i])
        if (i < u_printer_model.got.size())
          chk("byte", u_printer_model.got[i], expq[i]);
    end
    items.delete();
    expq.delete();
    u_printer_model.got.delete();
    $display("test %s done", name);
  endtask
  // ==========================================================
  // Scenarios
  task t_unconfigured;
    portConfigured = 1'b0;
    pulse();
    @(negedge clk);
    chk("busy idle", portBusyFlag, 1'b0);
    chk("ready idle", srcReady, 1'b0);
    portConfigured = 1'b1;
    $display("test unconfigured done");
  endtask
  task t_constants;
    slow = 1'b1;
    text("\"\"");
    add(SRC_ASCII, 16'h4142);
    add(SRC_ASCII, 16'h0043);
    add(SRC_HEX, 16'h3134);
    add(SRC_HEX, 16'hFFFF);
    add(SRC_END, 16'h0000);
    expq = '{8'h41, 8'h42, 8'h20, 8'h43, 8'h31, 8'h34, 8'hFF, 8'hFF};
    run_msg("constants", 1'b1);
    slow = 1'b0;
  endtask
  // The formatter goes idle at the faulty item, so nothing is sent after it.
  task err_case(input string name, input string s, input src_kind_t k);
    text(s);
    if (k != SRC_TEXT) add(k, 16'h4142);
    run_msg(name, 1'b0);
    chk("error code", errorCode, ERR_INVALID);
    chk("error flag", portCommErrorFlag, 1'b1);
  endtask
  task t_error;
    err_case("no quote", "A", SRC_TEXT);
    err_case("bad escape", "\"$Z", SRC_TEXT);
    err_case("bad hex", "\"$4G", SRC_TEXT);
    err_case("open text", "\"B", SRC_END);
    err_case("word in text", "\"", SRC_ASCII);
  endtask
  // A reset must clear the error code; a reset in mid-message must clear txValid, busy and ready.
  task t_reset;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk("reset error", errorCode, ERR_NONE);
    pulse();
    send('{kind: SRC_TEXT, data: 16'h0022});
    send('{kind: SRC_TEXT, data: 16'h0041});
    srst = 1'b1;
    srcValid = 1'b0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk("reset valid", txValid, 1'b0);
    chk("reset busy", portBusyFlag, 1'b0);
    chk("reset ready", srcReady, 1'b0);
    u_printer_model.got.delete();
    $display("test reset done");
  endtask
  task t_escapes;
    text("\"A$N$$$\"$41$0D$r$T$p$L$l$n$t$R$P\"");
    add(SRC_END, 16'h0000);
    expq = '{8'h41, 8'h0D, 8'h0A, 8'h24, 8'h22, 8'h41, 8'h0D, 8'h0D,
             8'h09, 8'h0C, 8'h0A, 8'h0A, 8'h0D, 8'h0A, 8'h09, 8'h0D, 8'h0C};
    run_msg("escapes", 1'b1);
    chk("error cleared", errorCode, ERR_NONE);
  endtask
  task t_length;
    text("\"");
    for (int i = 0; i < 130; i++) add(SRC_TEXT, 16'h0078);
    text("\"");
    add(SRC_END, 16'h0000);
    for (int i = 0; i < MAX_CHARS; i++) expq.push_back(8'h78);
    run_msg("length", 1'b1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_unconfigured();
    t_constants();
    t_error();
    t_reset();
    t_escapes();
    t_length();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
